// File: logic/dst_strobe_timing.sv
// Read strobe framing and command turnaround checks for a x16 DDR3 device.
// Assumes a PHY that drives the strobe pair from rise/fall half-cycle values
// and the enable, and forms the complement leg itself.
`timescale 1ns/1ns
module dst_strobe_timing
  import dst_pkg::*;
#(
  parameter int BANK_COUNT = BANKS
) (
  // Core side
  input wire logic clk_in,                        // Core clock, 100 MHz
  input wire logic reset_n_in,                    // Async reset, active low
  input wire logic [LAT_W-1:0] cfg_read_latency_in, // Read latency in link clocks
  input wire logic cfg_burst8_in,                 // 1: burst of 8, 0: burst of 4
  input wire logic err_clear_in,                  // Clears both error flags
  output logic read_done_out,                     // Pulse per finished read burst
  output logic rtp_err_out,                       // Sticky read-to-precharge error
  output logic wtr_err_out,                       // Sticky write-to-read error
  // Link side
  input wire logic ck_link_in,                    // Command clock from controller
  input wire logic cmd_read_in,                   // Read command this clock
  input wire logic cmd_write_in,                  // Write command this clock
  input wire logic cmd_precharge_in,              // Precharge command this clock
  input wire logic [BANK_W-1:0] cmd_bank_in,      // Bank of the command
  output logic strobe_rise_out,                   // Strobe level, first half clock
  output logic strobe_fall_out,                   // Strobe level, second half clock
  output logic strobe_oe_out                      // High while device drives strobe
);
  // ========================================================================
  // Link domain reset
  // ========================================================================
  logic lrst_meta_q; // Reset release, first stage
  logic lrst_n_q;    // Reset for link logic

  // Async assert, sync release
  always_ff @(posedge ck_link_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      lrst_meta_q <= 1'b0;
      lrst_n_q <= 1'b0;
    end else begin
      lrst_meta_q <= 1'b1;
      lrst_n_q <= lrst_meta_q;
    end
  end

  // ========================================================================
  // Configuration into link domain
  // ========================================================================
  logic [LAT_W:0] cfg_link; // Latency and burst flag, synchronised

  // Quasi-static config, change only while idle
  dst_sync2 #(.WIDTH(LAT_W + 1)) u_cfg_sync (
    .clk_in(ck_link_in),
    .reset_n_in(lrst_n_q),
    .async_in({cfg_burst8_in, cfg_read_latency_in}),
    .sync_out(cfg_link)
  );

  wire [CNT_W-1:0] lat = {1'b0, cfg_link[LAT_W-1:0]};    // Read latency
  wire [CNT_W-1:0] half_bl = cfg_link[LAT_W] ? BL8_HALF : BL4_HALF; // Burst clocks
  wire [CNT_W-1:0] drive_on = lat - CNT_W'(READ_PREAMBLE_CYC);
  wire [CNT_W-1:0] release_at = lat + half_bl;

  // ========================================================================
  // Read strobe sequencer
  // ========================================================================
  dst_phase_e phase_q;      // Current phase
  dst_phase_e phase_d;      // Next phase
  logic [CNT_W-1:0] cnt_q;  // Clocks since read command
  logic [CNT_W-1:0] cnt_d;  // Next count
  logic done_tgl_q;         // Toggles per finished burst

  // Count restarts on each read; a new read cuts the previous one
  wire busy = (phase_q != DST_IDLE);
  wire finishing = busy && !cmd_read_in && (cnt_q + 6'h01 == release_at);
  assign cnt_d = cmd_read_in ? 6'h01 : (busy ? cnt_q + 6'h01 : 6'h00);

  // Phase of the coming clock
  always_comb begin
    phase_d = DST_IDLE;
    if (cmd_read_in || busy) begin
      if (cnt_d >= release_at) begin
        phase_d = DST_IDLE;
      end else if (cnt_d >= lat) begin
        phase_d = DST_BURST;
      end else if (cnt_d >= drive_on) begin
        phase_d = DST_PRE;
      end else begin
        phase_d = DST_WAIT;
      end
    end
  end

  // Phase and count registers
  always_ff @(posedge ck_link_in or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      phase_q <= DST_IDLE;
      cnt_q <= 6'h00;
      done_tgl_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      if (finishing) begin
        done_tgl_q <= ~done_tgl_q;
      end
    end
  end

  // Strobe outputs from the coming phase
  always_ff @(posedge ck_link_in or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      strobe_rise_out <= 1'b0;
      strobe_fall_out <= 1'b0;
      strobe_oe_out <= 1'b0;
    end else begin
      case (phase_d)
        DST_PRE: begin
          strobe_rise_out <= 1'b0;
          strobe_fall_out <= 1'b0;
          strobe_oe_out <= 1'b1;
        end
        DST_BURST: begin
          strobe_rise_out <= 1'b1;
          strobe_fall_out <= 1'b0;
          strobe_oe_out <= 1'b1;
        end
        default: begin
          strobe_rise_out <= 1'b0;
          strobe_fall_out <= 1'b0;
          strobe_oe_out <= 1'b0;
        end
      endcase
    end
  end

  // ========================================================================
  // Turnaround checks
  // ========================================================================
  logic [TURN_W-1:0] rtp_cnt_q [BANK_COUNT]; // Per-bank read-to-precharge wait
  logic [TURN_W-1:0] wtr_cnt_q;              // Write-to-read wait
  logic [BANK_COUNT-1:0] rtp_hit;            // Early precharge per bank
  logic rtp_tgl_q;                           // Toggles per read-to-precharge error
  logic wtr_tgl_q;                           // Toggles per write-to-read error

  // One wait counter per bank
  genvar b;
  generate
    for (b = 0; b < BANK_COUNT; b++) begin : g_bank
      wire sel = (cmd_bank_in == BANK_W'(b));
      assign rtp_hit[b] = sel && cmd_precharge_in && (rtp_cnt_q[b] != '0);
      always_ff @(posedge ck_link_in or negedge lrst_n_q) begin
        if (!lrst_n_q) begin
          rtp_cnt_q[b] <= '0;
        end else if (sel && cmd_read_in) begin
          rtp_cnt_q[b] <= TURN_W'(RTP_CYC - 1);
        end else if (rtp_cnt_q[b] != '0) begin
          rtp_cnt_q[b] <= rtp_cnt_q[b] - 1'b1;
        end
      end
    end
  endgenerate

  wire wtr_hit = cmd_read_in && (wtr_cnt_q != '0);

  // Write wait counter and error toggles
  always_ff @(posedge ck_link_in or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      wtr_cnt_q <= '0;
      rtp_tgl_q <= 1'b0;
      wtr_tgl_q <= 1'b0;
    end else begin
      if (cmd_write_in) begin
        wtr_cnt_q <= TURN_W'(WTR_CYC - 1);
      end else if (wtr_cnt_q != '0) begin
        wtr_cnt_q <= wtr_cnt_q - 1'b1;
      end
      if (|rtp_hit) begin
        rtp_tgl_q <= ~rtp_tgl_q;
      end
      if (wtr_hit) begin
        wtr_tgl_q <= ~wtr_tgl_q;
      end
    end
  end

  // ========================================================================
  // Events into core domain
  // ========================================================================
  logic [2:0] ev_sync;  // Synchronised toggles
  logic [2:0] ev_seen_q; // Previous toggle levels

  dst_sync2 #(.WIDTH(3)) u_ev_sync (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .async_in({wtr_tgl_q, rtp_tgl_q, done_tgl_q}),
    .sync_out(ev_sync)
  );

  wire [2:0] ev_edge = ev_sync ^ ev_seen_q; // One-cycle event per toggle

  // Done pulse and sticky flags, set wins over clear
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ev_seen_q <= 3'h0;
      read_done_out <= 1'b0;
      rtp_err_out <= 1'b0;
      wtr_err_out <= 1'b0;
    end else begin
      ev_seen_q <= ev_sync;
      read_done_out <= ev_edge[0];
      rtp_err_out <= ev_edge[1] | (rtp_err_out & ~err_clear_in);
      wtr_err_out <= ev_edge[2] | (wtr_err_out & ~err_clear_in);
    end
  end
endmodule : dst_strobe_timing

// File: logic/dst_sync.sv
// Shared constants for the strobe timing block, and a two-flop level synchroniser.
// Assumes the package is compiled before any module that imports it.
`timescale 1ns/1ns
// ==========================================================================
// Package
// ==========================================================================
package dst_pkg;
  // Link clock period in picoseconds
  localparam int LINK_PERIOD_PS = 6000;
  // Strobe framing minima, in hundredths of a clock period
  localparam int READ_PREAMBLE_TIME_CK100 = 90;
  localparam int READ_POSTAMBLE_TIME_CK100 = 30;
  localparam int STROBE_OUT_HIGH_TIME_CK100 = 40;
  localparam int STROBE_OUT_LOW_TIME_CK100 = 40;
  // Preamble length in whole clocks, rounded up
  localparam int READ_PREAMBLE_CYC = (READ_PREAMBLE_TIME_CK100 + 99) / 100;
  // Turnaround minima
  localparam int READ_TO_PRECHARGE_DELAY_PS = 7500;
  localparam int WRITE_TO_READ_DELAY_PS = 7500;
  localparam int TURN_MIN_CLOCKS = 4;
  // Time to clocks, rounded up, never below one
  function automatic int dst_ceil_cyc(input int ps);
    int c;
    c = (ps + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction : dst_ceil_cyc
  // Larger of a clock count and a converted time
  function automatic int dst_max_cyc(input int ps, input int clocks);
    int c;
    c = dst_ceil_cyc(ps);
    return (c > clocks) ? c : clocks;
  endfunction : dst_max_cyc
  localparam int RTP_CYC = dst_max_cyc(READ_TO_PRECHARGE_DELAY_PS, TURN_MIN_CLOCKS);
  localparam int WTR_CYC = dst_max_cyc(WRITE_TO_READ_DELAY_PS, TURN_MIN_CLOCKS);
  // Sizes
  localparam int BANKS = 8;
  localparam int BANK_W = 3;
  localparam int LAT_W = 5;
  localparam int CNT_W = 6;
  localparam int TURN_W = 4;
  localparam logic [CNT_W-1:0] BL8_HALF = 6'h04;
  localparam logic [CNT_W-1:0] BL4_HALF = 6'h02;
  // Reset values
  localparam logic [LAT_W-1:0] LAT_RESET = 5'h05;
  // Read strobe phase
  typedef enum logic [1:0] {
    DST_IDLE = 2'b00,
    DST_WAIT = 2'b01,
    DST_PRE = 2'b10,
    DST_BURST = 2'b11
  } dst_phase_e;
endpackage : dst_pkg

// ==========================================================================
// Two-flop synchroniser
// ==========================================================================
module dst_sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,                 // Destination clock
  input wire logic reset_n_in,             // Destination reset, async low
  input wire logic [WIDTH-1:0] async_in,   // Level from another domain
  output logic [WIDTH-1:0] sync_out        // Synchronised level
);
  logic [WIDTH-1:0] meta_q; // First stage, read only by second stage

  // Two stages, constant reset
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule : dst_sync2

// File: tb/dst_timing_sva.sv
// Concurrent checks on the read strobe framing and the turnaround flags.
// Assumes it is bound onto dst_strobe_timing and sees only its ports.
`timescale 1ns/1ns
module dst_timing_sva
  import dst_pkg::*;
#(
  parameter int BANK_COUNT = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic ck_link_in,
  input wire logic [LAT_W-1:0] cfg_read_latency_in,
  input wire logic cfg_burst8_in,
  input wire logic err_clear_in,
  input wire logic cmd_read_in,
  input wire logic read_done_out,
  input wire logic rtp_err_out,
  input wire logic wtr_err_out,
  input wire logic strobe_rise_out,
  input wire logic strobe_fall_out,
  input wire logic strobe_oe_out
);
  // ==========================================================================
  // Link clocks since the last read, zero before any
  // ==========================================================================
  logic [CNT_W-1:0] age_q; // Sampled age
  logic [CNT_W-1:0] age_d; // Next age, saturating
  logic [CNT_W-1:0] lat; // Latency widened
  logic [CNT_W-1:0] last; // First released clock, latency plus half burst
  logic [CNT_W-1:0] pre; // Preamble clock, one before latency
  logic age_run; // Age still counting
  assign lat = CNT_W'(cfg_read_latency_in);
  assign pre = lat - 6'h01;
  assign last = lat + (cfg_burst8_in ? BL8_HALF : BL4_HALF);
  assign age_run = (age_q != 6'h00) && (age_q != 6'h3F);
  assign age_d = cmd_read_in ? 6'h01 : (age_run ? age_q + 6'h01 : age_q);
  // Age register
  always_ff @(posedge ck_link_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      age_q <= 6'h00;
    end else begin
      age_q <= age_d;
    end
  end
  // ==========================================================================
  // Assertions
  // ==========================================================================
  chk_pre_low: assert property (@(posedge ck_link_in) disable iff (!reset_n_in)
    age_q == pre |-> strobe_oe_out && !strobe_rise_out) else $error("preamble wrong");
  chk_oe_window: assert property (@(posedge ck_link_in) disable iff (!reset_n_in)
    age_q != 6'h00 |-> strobe_oe_out == (age_q >= pre && age_q < last))
    else $error("strobe enable window wrong");
  chk_burst_high: assert property (@(posedge ck_link_in) disable iff (!reset_n_in)
    age_q >= lat && age_q < last |-> strobe_rise_out) else $error("burst phase wrong");
  chk_release_low: assert property (@(posedge ck_link_in) disable iff (!reset_n_in)
    age_q == last |-> !strobe_oe_out && !strobe_rise_out) else $error("release wrong");
  chk_fall_low: assert property (@(posedge ck_link_in) disable iff (!reset_n_in)
    strobe_oe_out |-> !strobe_fall_out) else $error("second half not low");
  chk_idle_quiet: assert property (@(posedge ck_link_in) disable iff (!reset_n_in)
    age_q == 6'h00 |-> !strobe_oe_out) else $error("strobe driven with no read");
  chk_done_pulse: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    read_done_out |=> !read_done_out) else $error("done pulse too long");
  chk_rtp_sticky: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    rtp_err_out && !err_clear_in |=> rtp_err_out) else $error("rtp flag dropped");
  chk_wtr_sticky: assert property (@(posedge clk_in) disable iff (!reset_n_in)
    wtr_err_out && !err_clear_in |=> wtr_err_out) else $error("wtr flag dropped");
  // Main scenarios reached
  cov_burst_end: cover property (@(posedge ck_link_in) age_q == last);
  cov_rtp: cover property (@(posedge clk_in) $rose(rtp_err_out));
  cov_wtr: cover property (@(posedge clk_in) $rose(wtr_err_out));
endmodule : dst_timing_sva

bind dst_strobe_timing dst_timing_sva #(.BANK_COUNT(BANK_COUNT)) u_sva (.clk_in, .reset_n_in,
  .ck_link_in, .cfg_read_latency_in, .cfg_burst8_in, .err_clear_in, .cmd_read_in,
  .read_done_out, .rtp_err_out, .wtr_err_out, .strobe_rise_out, .strobe_fall_out,
  .strobe_oe_out);

// File: tb/dst_ctrl_model.sv
// Memory controller model: free command clock and one command per link clock.
// Assumes the caller spaces commands; it breaks spacing only on request.
`timescale 1ns/1ns
module dst_ctrl_model
  import dst_pkg::*;
(
  output logic ck_link_out,
  output logic cmd_read_out,
  output logic cmd_write_out,
  output logic cmd_precharge_out,
  output logic [BANK_W-1:0] cmd_bank_out,
  output logic wstrobe_out,
  output logic wstrobe_oe_out
);
  // Command clock, 6 ns, offset from the core clock
  initial begin
    ck_link_out = 1'b0;
    cmd_read_out = 1'b0;
    cmd_write_out = 1'b0;
    cmd_precharge_out = 1'b0;
    cmd_bank_out = 3'h0;
    wstrobe_out = 1'b0;
    wstrobe_oe_out = 1'b0;
    #1;
    forever #3 ck_link_out = ~ck_link_out;
  end
  // One command slot; idle slots scramble the bank lines
  task automatic cmd(input logic r, input logic w, input logic p, input logic [2:0] b);
    @(negedge ck_link_out);
    cmd_read_out = r;
    cmd_write_out = w;
    cmd_precharge_out = p;
    cmd_bank_out = (r | w | p) ? b : ~cmd_bank_out;
  endtask : cmd
  // Write strobe: one low clock, pulses locked to the clock, half clock low after
  always @(posedge ck_link_out) begin
    if (cmd_write_out === 1'b1) begin
      wstrobe_oe_out = 1'b1;
      wstrobe_out = 1'b0;
      repeat (BL8_HALF) begin
        @(posedge ck_link_out);
        wstrobe_out = 1'b1;
        @(negedge ck_link_out);
        wstrobe_out = 1'b0;
      end
      @(posedge ck_link_out);
      wstrobe_oe_out = 1'b0;
    end
  end
endmodule : dst_ctrl_model

// File: tb/tb_top.sv
// Self-checking bench for dst_strobe_timing with a controller model.
// Assumes the checker is bound onto the design.
`timescale 1ns/1ns
module tb_top;
  import dst_pkg::*;
  typedef struct packed {logic wtr; logic [2:0] gap; logic [2:0] bank; logic exp;} dst_row_s;
  // Turnaround rows: kind, command gap, second bank, flag expected
  localparam dst_row_s ROWS [8] = '{'{1'b0, 3'h1, 3'h2, 1'b1}, '{1'b0, 3'h3, 3'h2, 1'b1},
    '{1'b0, 3'h4, 3'h2, 1'b0}, '{1'b0, 3'h1, 3'h5, 1'b0}, '{1'b1, 3'h0, 3'h0, 1'b0},
    '{1'b1, 3'h1, 3'h0, 1'b1}, '{1'b1, 3'h3, 3'h0, 1'b1}, '{1'b1, 3'h4, 3'h0, 1'b0}};
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [LAT_W-1:0] cfg_read_latency_in = 5'h05;
  logic cfg_burst8_in = 1'b1;
  logic err_clear_in = 1'b0;
  logic read_done_out, rtp_err_out, wtr_err_out, strobe_rise_out, strobe_fall_out;
  logic strobe_oe_out, ck_link_in, cmd_read_in, cmd_write_in, cmd_precharge_in;
  logic [BANK_W-1:0] cmd_bank_in;
  logic wstrobe, wstrobe_oe;
  int failures = 0;
  int checked = 0;
  int dones = 0;
  int wedges = 0;
  always #5 clk_in = ~clk_in;
  always @(negedge clk_in) if (read_done_out === 1'b1) dones++;
  always @(posedge wstrobe) if (wstrobe_oe === 1'b1) wedges++;
  dst_ctrl_model u_ctrl (.ck_link_out(ck_link_in), .cmd_read_out(cmd_read_in),
    .cmd_write_out(cmd_write_in), .cmd_precharge_out(cmd_precharge_in),
    .cmd_bank_out(cmd_bank_in), .wstrobe_out(wstrobe), .wstrobe_oe_out(wstrobe_oe));
  dst_strobe_timing DUT (.clk_in, .reset_n_in, .cfg_read_latency_in, .cfg_burst8_in,
    .err_clear_in, .read_done_out, .rtp_err_out, .wtr_err_out, .ck_link_in, .cmd_read_in,
    .cmd_write_in, .cmd_precharge_in, .cmd_bank_in, .strobe_rise_out, .strobe_fall_out,
    .strobe_oe_out);
  task automatic check(input string what, input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %b seen %b", what, exp, seen);
    end
  endtask : check
  task automatic core_wait(input int n);
    repeat (n) @(negedge clk_in);
  endtask : core_wait
  task automatic complete_run;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  // Watchdog
  initial begin
    #20000;
    failures++;
    complete_run();
  end
  // Main sequence
  initial begin
    core_wait(10);
    reset_n_in = 1'b1;
    core_wait(4);
    check("oe idle", strobe_oe_out, 1'b0);
    for (int i = 0; i < 8; i++) begin
      core_wait(1);
      err_clear_in = 1'b1;
      core_wait(1);
      err_clear_in = 1'b0;
      core_wait(4);
      check("cleared", ROWS[i].wtr ? wtr_err_out : rtp_err_out, 1'b0);
      u_ctrl.cmd(!ROWS[i].wtr || ROWS[i].gap == 3'h0, ROWS[i].wtr, 1'b0, 3'h2 & {3{!ROWS[i].wtr}});
      for (int g = 1; g < ROWS[i].gap; g++) u_ctrl.cmd(1'b0, 1'b0, 1'b0, 3'h0);
      if (ROWS[i].gap != 3'h0) u_ctrl.cmd(ROWS[i].wtr, 1'b0, !ROWS[i].wtr, ROWS[i].bank);
      u_ctrl.cmd(1'b0, 1'b0, 1'b0, 3'h0);
      core_wait(20);
      check("turn flag", ROWS[i].wtr ? wtr_err_out : rtp_err_out, ROWS[i].exp);
    end
    check("write strobe edges", wedges == 16, 1'b1);
    // Latency and burst corners, one done pulse each
    for (int k = 0; k < 3; k++) begin
      cfg_read_latency_in = (k == 0) ? 5'h05 : ((k == 1) ? 5'h02 : 5'h1F);
      cfg_burst8_in = (k != 1);
      core_wait(4);
      dones = 0;
      u_ctrl.cmd(1'b1, 1'b0, 1'b0, 3'h1);
      u_ctrl.cmd(1'b0, 1'b0, 1'b0, 3'h0);
      core_wait(40);
      check("one done", dones == 1, 1'b1);
    end
    // Read cut by a second read in its burst
    cfg_read_latency_in = 5'h05;
    cfg_burst8_in = 1'b1;
    core_wait(4);
    dones = 0;
    u_ctrl.cmd(1'b1, 1'b0, 1'b0, 3'h3);
    repeat (5) u_ctrl.cmd(1'b0, 1'b0, 1'b0, 3'h0);
    u_ctrl.cmd(1'b1, 1'b0, 1'b0, 3'h3);
    u_ctrl.cmd(1'b0, 1'b0, 1'b0, 3'h0);
    core_wait(30);
    check("cut done", dones == 1, 1'b1);
    // Early precharge sets the flag that reset must clear
    u_ctrl.cmd(1'b1, 1'b0, 1'b0, 3'h3);
    u_ctrl.cmd(1'b0, 1'b0, 1'b1, 3'h3);
    u_ctrl.cmd(1'b0, 1'b0, 1'b0, 3'h0);
    core_wait(20);
    check("rtp before reset", rtp_err_out, 1'b1);
    // Reset in mid burst releases the strobe
    u_ctrl.cmd(1'b1, 1'b0, 1'b0, 3'h3);
    u_ctrl.cmd(1'b0, 1'b0, 1'b0, 3'h0);
    core_wait(3);
    check("oe before reset", strobe_oe_out, 1'b1);
    reset_n_in = 1'b0;
    core_wait(3);
    check("oe in reset", strobe_oe_out, 1'b0);
    reset_n_in = 1'b1;
    core_wait(4);
    check("rtp after reset", rtp_err_out, 1'b0);
    complete_run();
  end
endmodule : tb_top
